// [rtl/wdt_consts.svh]
// offsets, field positions, reset values and counts for the watchdog
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH
`define WDT_OFF_CONTROL   12'h000
`define WDT_OFF_MODE      12'h004
`define WDT_OFF_STATUS    12'h008
`define WDT_OFF_INT_EN    12'h00C
`define WDT_OFF_INT_CLR   12'h010
`define WDT_OFF_INT_STAT  12'h014
`define WDT_MODE_RESET    32'h3FFF_2FFF
`define WDT_COUNT_RESET   12'hFFF
`define WDT_KEY_VALUE     8'hA5
`define WDT_KEY_MSB       31
`define WDT_KEY_LSB       24
`define WDT_RESTART_BIT   0
`define WDT_RELOAD_MSB    11
`define WDT_RELOAD_LSB    0
`define WDT_IEN_BIT       12
`define WDT_RSTEN_BIT     13
`define WDT_PROC_BIT      14
`define WDT_DIS_BIT       15
`define WDT_DELTA_MSB     27
`define WDT_DELTA_LSB     16
`define WDT_DBGHLT_BIT    28
`define WDT_IDLEHLT_BIT   29
`define WDT_UNF_BIT       0
`define WDT_ERR_BIT       1
`define WDT_PRESCALE      128
`endif

// [rtl/wdt_pkg.sv]
// types shared by the watchdog files
`default_nettype none
package wdt_pkg;
    typedef logic [11:0] count_t;
    typedef enum logic [1:0] {
        FAULT_NONE,
        FAULT_PROC,
        FAULT_ALL
    } fault_scope_e;
endpackage : wdt_pkg
`default_nettype wire

// [rtl/wdt_prescaler.sv]
// slow clock tick divider feeding the watchdog counter
`timescale 1ns/1ps
`default_nettype none
module wdt_prescaler #(
    parameter int DIV = 128
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic slow_tick,
    input  wire logic clear,
    output logic      tick
);
    localparam int W = $clog2(DIV);
    logic [W-1:0] cnt_r;

    // refuse a divide the counter width cannot serve
    if (DIV < 2 || (1 << W) != DIV) begin : g_bad_div
        $error("prescaler divide must be a power of two");
    end

    // count slow ticks, restart on clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cnt_r <= '0;
        else if (clear)
            cnt_r <= '0;
        else if (slow_tick)
            cnt_r <= cnt_r + 1'b1;
    end

    assign tick = slow_tick && !clear && (cnt_r == W'(DIV - 1));
endmodule : wdt_prescaler
`default_nettype wire

// [rtl/wdt_edge_sync.sv]
// two-flop synchroniser with a rising edge pulse
`timescale 1ns/1ps
`default_nettype none
module wdt_edge_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic async_in,
    output logic      level,
    output logic      rise
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    // meta_r is read by sync_r only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign rise  = sync_r && !last_r;
endmodule : wdt_edge_sync
`default_nettype wire

// [rtl/windowed_watchdog_timer.sv]
// windowed watchdog with apb registers, fault and interrupt outputs
`timescale 1ns/1ps
`default_nettype none
`include "wdt_consts.svh"
module windowed_watchdog_timer #(
    parameter int PRESCALE = `WDT_PRESCALE
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        backup_resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [31:0] prdata,
    input  wire logic        slow_clk,
    input  wire logic        debug_state,
    input  wire logic        idle_mode,
    output logic             wdt_fault,
    output logic             fault_proc_only,
    output logic             fault_all,
    output logic             wdt_irq,
    output logic             sys_irq
);
    logic                 sel_wr;
    logic                 sel_rd;
    logic                 key_ok;
    logic                 restart;
    logic                 mode_wr;
    logic          [31:0] mode_r;
    logic                 mode_locked_r;
    logic                 rsten_r;
    wdt_pkg::count_t      count_r;
    wdt_pkg::count_t      reload;
    wdt_pkg::count_t      delta;
    logic                 unf_r;
    logic                 err_r;
    logic                 fault_r;
    logic           [1:0] ien_r;
    logic           [1:0] isr_r;
    logic                 tick;
    logic                 slow_rise;
    logic                 dbg_s;
    logic                 idle_s;
    logic                 halted;
    logic                 underflow;
    logic                 win_err;
    logic                 sr_read;
    logic                 rst_seen_r;
    logic                 bkp_meta_r;
    logic                 bkp_sync_r;
    wdt_pkg::fault_scope_e scope;

    // refuse a prescale that leaves no divider
    if (PRESCALE < 2) begin : g_bad_prescale
        $error("prescale too small");
    end

    // single-cycle apb access phase
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign sel_wr  = psel && penable && pwrite;
    assign sel_rd  = psel && penable && !pwrite;
    assign key_ok  = pwdata[`WDT_KEY_MSB:`WDT_KEY_LSB] == `WDT_KEY_VALUE;

    // control write, key checked
    assign restart = sel_wr && paddr == `WDT_OFF_CONTROL && key_ok
                     && pwdata[`WDT_RESTART_BIT];
    assign mode_wr = sel_wr && paddr == `WDT_OFF_MODE && !mode_locked_r;
    assign sr_read = sel_rd && paddr == `WDT_OFF_STATUS;

    assign reload = mode_r[`WDT_RELOAD_MSB:`WDT_RELOAD_LSB];
    assign delta  = mode_r[`WDT_DELTA_MSB:`WDT_DELTA_LSB];

    // synchronise the slow clock and mode inputs
    wdt_edge_sync u_slow (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (slow_clk),
        .level    (),
        .rise     (slow_rise)
    );
    wdt_edge_sync u_dbg (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (debug_state),
        .level    (dbg_s),
        .rise     ()
    );
    wdt_edge_sync u_idle (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (idle_mode),
        .level    (idle_s),
        .rise     ()
    );

    // prescaler restarted by any reload
    wdt_prescaler #(.DIV(PRESCALE)) u_pre (
        .pclk      (pclk),
        .presetn   (presetn),
        .slow_tick (slow_rise),
        .clear     ((restart && !win_err) || mode_wr),
        .tick      (tick)
    );

    // halt conditions
    assign halted = mode_r[`WDT_DIS_BIT]
                 || (mode_r[`WDT_DBGHLT_BIT] && dbg_s)
                 || (mode_r[`WDT_IDLEHLT_BIT] && idle_s);

    assign underflow = tick && !halted && count_r == '0;
    // window check, delta >= reload means never above delta until an underflow wraps the count to FFF
    assign win_err = restart && (count_r > delta);

    // mode register, write once until processor reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r        <= `WDT_MODE_RESET;
            mode_locked_r <= 1'b0;
        end else if (mode_wr) begin
            mode_r        <= {2'b00, pwdata[29:0]};
            mode_locked_r <= 1'b1;
        end
    end

    // backup reset synchroniser
    always_ff @(posedge pclk or negedge backup_resetn) begin
        if (!backup_resetn) begin
            bkp_meta_r <= 1'b1;
            bkp_sync_r <= 1'b1;
        end else begin
            bkp_meta_r <= 1'b0;
            bkp_sync_r <= bkp_meta_r;
        end
    end

    // reset enable: set by backup or processor reset, else follows mode writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            rst_seen_r <= 1'b0;
        else
            rst_seen_r <= 1'b1;
    end
    always_ff @(posedge pclk or negedge backup_resetn) begin
        if (!backup_resetn)
            rsten_r <= 1'b1;
        else if (bkp_sync_r)
            rsten_r <= 1'b1;
        else if (mode_wr)
            rsten_r <= pwdata[`WDT_RSTEN_BIT];
        else if (!rst_seen_r)
            rsten_r <= mode_r[`WDT_RSTEN_BIT];
    end

    // down counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            count_r <= `WDT_COUNT_RESET;
        else if (mode_wr)
            count_r <= pwdata[`WDT_RELOAD_MSB:`WDT_RELOAD_LSB];
        else if (restart && !win_err)
            count_r <= reload;
        else if (tick && !halted)
            count_r <= count_r - 1'b1;
    end

    // sticky flags, event wins over the read clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unf_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            unf_r <= underflow || (unf_r && !sr_read);
            err_r <= win_err || (err_r && !sr_read);
        end
    end

    // fault output to reset controller
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            fault_r <= 1'b0;
        else if ((underflow && rsten_r) || win_err)
            fault_r <= 1'b1;
        else if (sr_read)
            fault_r <= 1'b0;
    end

    assign scope = !fault_r ? wdt_pkg::FAULT_NONE :
                   !rsten_r ? wdt_pkg::FAULT_NONE :
                   mode_r[`WDT_PROC_BIT] ? wdt_pkg::FAULT_PROC :
                   wdt_pkg::FAULT_ALL;
    assign wdt_fault       = fault_r;
    assign fault_proc_only = scope == wdt_pkg::FAULT_PROC;
    assign fault_all       = scope == wdt_pkg::FAULT_ALL;

    // watchdog interrupt
    assign wdt_irq = mode_r[`WDT_IEN_BIT] && (unf_r || err_r);

    // system interrupt status, enable and clear registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ien_r <= 2'h0;
        else if (sel_wr && paddr == `WDT_OFF_INT_EN)
            ien_r <= pwdata[1:0];
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            isr_r <= 2'h0;
        else begin
            isr_r[0] <= underflow || (isr_r[0] && !(sel_wr
                        && paddr == `WDT_OFF_INT_CLR && pwdata[0]));
            isr_r[1] <= win_err || (isr_r[1] && !(sel_wr
                        && paddr == `WDT_OFF_INT_CLR && pwdata[1]));
        end
    end
    assign sys_irq = |(isr_r & ien_r);

    // read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite) begin
            case (paddr)
                `WDT_OFF_MODE:   prdata <= mode_r;
                `WDT_OFF_STATUS: prdata <= {30'h0, err_r, unf_r};
                `WDT_OFF_INT_EN: prdata <= {30'h0, ien_r};
                `WDT_OFF_INT_STAT: prdata <= {30'h0, isr_r};
                default:         prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule : windowed_watchdog_timer
`default_nettype wire

// [verif/wdt_assertions.sv]
// port checker for the windowed watchdog
`timescale 1ns/1ps
`default_nettype none
module wdt_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        wdt_fault,
    input wire logic        fault_proc_only,
    input wire logic        fault_all,
    input wire logic        wdt_irq
);
    logic stat_rd;
    // status read in its access phase
    assign stat_rd = psel && penable && !pwrite && paddr == 12'h008;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_rd(a);
        psel && penable && !pwrite && paddr == a;
    endsequence
    property p_scope; !(fault_all && fault_proc_only); endproperty
    a_scope: assert property (p_scope) else $error("both scopes");
    property p_scope_f; fault_all || fault_proc_only |-> wdt_fault; endproperty
    a_scope_f: assert property (p_scope_f) else $error("scope");
    property p_f_hold; wdt_fault && !stat_rd |=> wdt_fault; endproperty
    a_f_hold: assert property (p_f_hold) else $error("fault drop");
    property p_i_hold; wdt_irq && !stat_rd |=> wdt_irq; endproperty
    a_i_hold: assert property (p_i_hold) else $error("irq drop");
    property p_f_fell; $fell(wdt_fault) |-> $past(stat_rd); endproperty
    a_f_fell: assert property (p_f_fell) else $error("fault fell");
    property p_i_fell; $fell(wdt_irq) |-> $past(stat_rd); endproperty
    a_i_fell: assert property (p_i_fell) else $error("irq fell");
    property p_stat; s_rd(12'h008) |-> prdata[31:2] == 30'h0; endproperty
    a_stat: assert property (p_stat) else $error("status bits");
    property p_mode; s_rd(12'h004) |-> prdata[31:30] == 2'b00; endproperty
    a_mode: assert property (p_mode) else $error("mode bits");
endmodule : wdt_checker
bind windowed_watchdog_timer wdt_checker i_wdt_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .wdt_fault(wdt_fault), .fault_proc_only(fault_proc_only),
    .fault_all(fault_all), .wdt_irq(wdt_irq));
`default_nettype wire

// [verif/wdt_slow_clock_model.sv]
// slow clock source feeding the watchdog
`timescale 1ns/1ps
`default_nettype none
module wdt_slow_clock_model #(
    parameter int HALF_NS = 85
) (
    output logic slow_clk
);
    // free running, phase unrelated to pclk
    initial begin
        slow_clk = 1'b0;
        forever #(HALF_NS) slow_clk = ~slow_clk;
    end
endmodule : wdt_slow_clock_model
`default_nettype wire

// [verif/windowed_watchdog_timer_tb_top.sv]
// self-checking bench for the windowed watchdog
`timescale 1ns/1ps
`default_nettype none
`include "wdt_consts.svh"
module windowed_watchdog_timer_tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        backup_resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        debug_state = 1'b0;
    logic        idle_mode = 1'b0;
    logic [31:0] rd;
    logic        er;
    logic [31:0] m;
    logic [11:0] r;
    logic [5:0]  flg [3] = '{6'h0A, 6'h12, 6'h22};
    int          mismatches = 0;
    int          total_checks = 0;
    int          cycles = 0;
    wire logic   pready, pslverr, wdt_fault, fault_proc_only, fault_all;
    wire logic   wdt_irq, sys_irq, slow_clk;
    wire logic [31:0] prdata;
    windowed_watchdog_timer #(.PRESCALE(2)) i_windowed_watchdog_timer (
        .pclk(pclk), .presetn(presetn), .backup_resetn(backup_resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .slow_clk(slow_clk), .debug_state(debug_state),
        .idle_mode(idle_mode), .wdt_fault(wdt_fault),
        .fault_proc_only(fault_proc_only), .fault_all(fault_all),
        .wdt_irq(wdt_irq), .sys_irq(sys_irq));
    wdt_slow_clock_model #(.HALF_NS(85)) i_wdt_slow_clock_model (
        .slow_clk(slow_clk));
    // 40 MHz clock
    always #12.5 pclk = ~pclk;
    // hang guard
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    function automatic logic [31:0] mk_mode(input logic [11:0] rel,
            input logic [11:0] dlt, input logic [5:0] f);
        mk_mode = {2'b00, f[5:4], dlt, f[3:0], rel};
    endfunction : mk_mode
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a,
            input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rchk(input string nm, input logic [11:0] a,
            input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, rd, e);
    endtask : rchk
    task automatic settle();
        @(negedge pclk);
    endtask : settle
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset
    task automatic wait_fault(input int lim);
        int n;
        n = 0;
        while (wdt_fault !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask : wait_fault
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : complete_run
    // main sequence
    initial begin
        void'($urandom(32'had36));
        do_reset();
        backup_resetn <= 1'b1;
        rchk("mode", `WDT_OFF_MODE, mk_mode(12'hFFF, 12'hFFF, 6'h32));
        // restart at reset, delta equals reload so no error
        apb(1'b1, `WDT_OFF_CONTROL, 32'hA500_0001);
        rchk("status", `WDT_OFF_STATUS, 32'h0000_0000);
        r = 12'(8 + $urandom_range(7));
        m = mk_mode(r, 12'h002, 6'h07);
        // reserved top bits must not stick
        apb(1'b1, `WDT_OFF_MODE, {2'b11, m[29:0]});
        apb(1'b1, `WDT_OFF_MODE, 32'h0000_2001);
        chk("mode err", {31'h0, er}, 32'h0);
        rchk("mode", `WDT_OFF_MODE, m);
        apb(1'b1, `WDT_OFF_INT_EN, 32'h0000_0003);
        apb(1'b1, `WDT_OFF_CONTROL, 32'hA400_0001);
        rchk("status", `WDT_OFF_STATUS, 32'h0000_0000);
        apb(1'b1, `WDT_OFF_CONTROL, 32'hA500_0001);
        settle();
        chk("scope", {29'h0, wdt_fault, fault_proc_only, fault_all}, 32'h6);
        chk("irq", {30'h0, wdt_irq, sys_irq}, 32'h3);
        rchk("irq status", `WDT_OFF_INT_STAT, 32'h0000_0002);
        apb(1'b1, `WDT_OFF_INT_CLR, 32'h0000_0003);
        settle();
        chk("cleared", {31'h0, sys_irq}, 32'h0);
        rchk("status", `WDT_OFF_STATUS, 32'h0000_0002);
        settle();
        chk("read clr", {30'h0, wdt_fault, wdt_irq}, 32'h0);
        wait_fault(2000);
        settle();
        chk("scope", {29'h0, wdt_fault, fault_proc_only, fault_all}, 32'h6);
        chk("sys irq", {31'h0, sys_irq}, 32'h1);
        apb(1'b1, `WDT_OFF_INT_EN, 32'h0000_0000);
        settle();
        chk("masked", {31'h0, sys_irq}, 32'h0);
        rchk("status", `WDT_OFF_STATUS, 32'h0000_0001);
        // disable, debug halt, idle halt
        for (int i = 0; i < 3; i++) begin
            do_reset();
            debug_state <= (i == 1);
            idle_mode   <= (i == 2);
            apb(1'b1, `WDT_OFF_MODE, mk_mode(12'h002, 12'h000, flg[i]));
            repeat (400) @(posedge pclk);
            chk("halted", {31'h0, wdt_fault}, 32'h0);
            if (i == 0) apb(1'b1, `WDT_OFF_CONTROL, 32'hA500_0001);
            debug_state <= 1'b0;
            idle_mode   <= 1'b0;
            wait_fault(2000);
            settle();
            chk("all", {29'h0, wdt_fault, fault_proc_only, fault_all}, 32'h5);
            chk("no irq", {31'h0, wdt_irq}, 32'h0);
        end
        do_reset();
        settle();
        chk("reset", {31'h0, wdt_fault}, 32'h0);
        complete_run();
    end
endmodule : windowed_watchdog_timer_tb_top
`default_nettype wire
